// File: shared/serial_frame_pkg.sv
// Constants and types for the serial frame and parity control block.
// Assumes a single 10 MHz clock and a 32-bit AHB-Lite register bus.
`default_nettype none
package serial_frame_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] FRAME_CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] LIN_CTRL_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RX9_BIT = 7;
  localparam int CTRL_TX9_BIT = 6;
  localparam int CTRL_DIS_BIT = 5;
  localparam int CTRL_WORD9_BIT = 4;
  localparam int CTRL_WAKE_BIT = 3;
  localparam int CTRL_PAR_ON_BIT = 2;
  localparam int CTRL_ODD_BIT = 1;
  localparam int CTRL_PIE_BIT = 0;
  localparam int STAT_PE_BIT = 0;
  localparam int STAT_FE_BIT = 1;
  localparam int STAT_RXRDY_BIT = 5;
  localparam int STAT_TXEMPTY_BIT = 7;
  localparam int LIN_MODE_BIT = 0;
  localparam int LIN_PAR_BIT = 1;
  localparam int LIN_HDM_BIT = 2;
  localparam int LIN_MUTE_BIT = 3;
  localparam int IRQ_PE_BIT = 0;
  localparam int IRQ_FE_BIT = 1;
  localparam int IRQ_RX_BIT = 2;
  localparam int IRQ_TX_BIT = 3;
  localparam int IRQ_WIDTH = 4;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] LIN_RESET = 4'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam int OS_DIVIDE = 65;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [7:0] IDLE_TICKS_8 = 8'h9f;
  localparam logic [7:0] IDLE_TICKS_9 = 8'haf;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    LINE_IDLE = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA = 2'b11,
    LINE_STOP = 2'b10
  } line_state_type;

  typedef struct packed
  {
    logic nine_bits;
    logic parity_on;
    logic parity_odd;
    logic lin_parity;
  } frame_cfg_type;

  typedef struct packed
  {
    logic [8:0] data;
    logic parity_error;
    logic framing_error;
  } rx_word_type;

endpackage
`default_nettype wire

// File: design/serial_frame_engine.sv
// Transmit and receive frame shifters with parity insert and check.
// Assumes a 16x oversample enable and a line input already synchronised.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_engine
  import serial_frame_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic os_tick,
  // Frame format
  input wire frame_cfg_type cfg,
  // Transmit side
  input wire logic tx_start,
  input wire logic [8:0] tx_word,
  output logic tx_busy,
  output logic tx_done,
  output logic tx_line,
  // Receive side
  input wire logic rx_line,
  output logic rx_busy,
  output logic rx_done,
  output var rx_word_type rx_word,
  output logic idle_line
);

  // ****************************************
  // Transmitter
  // ****************************************
  line_state_type tx_state_reg, tx_state_next;
  logic [3:0] tx_tick_reg, tx_tick_next, tx_bit_reg, tx_bit_next;
  logic [8:0] tx_shift_reg, tx_shift_next;
  frame_cfg_type tx_cfg_reg, tx_cfg_next;
  logic tx_done_reg, tx_done_next;

  // Format is latched at the start bit so mid-frame writes wait a byte
  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_tick_next = tx_tick_reg;
    tx_bit_next = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_cfg_next = tx_cfg_reg;
    tx_done_next = 1'b0;
    if (tx_state_reg == LINE_IDLE)
    begin
      if (tx_start)
      begin
        tx_cfg_next = cfg;
        tx_shift_next = tx_word;
        if (cfg.parity_on && !cfg.lin_parity)
        begin
          if (cfg.nine_bits)
            tx_shift_next[8] = ^tx_word[7:0] ^ cfg.parity_odd;
          else
            tx_shift_next[7] = ^tx_word[6:0] ^ cfg.parity_odd;
        end
        tx_state_next = LINE_START;
        tx_tick_next = 4'h0;
      end
    end
    else if (os_tick)
    begin
      tx_tick_next = tx_tick_reg + 4'h1;
      if (tx_tick_reg == TICK_LAST)
      begin
        case (tx_state_reg)
          LINE_START:
          begin
            tx_state_next = LINE_DATA;
            tx_bit_next = 4'h0;
          end
          LINE_DATA:
          begin
            tx_shift_next = {1'b0, tx_shift_reg[8:1]};
            tx_bit_next = tx_bit_reg + 4'h1;
            if (tx_bit_reg == (tx_cfg_reg.nine_bits ? 4'h8 : 4'h7))
              tx_state_next = LINE_STOP;
          end
          default:
          begin
            tx_state_next = LINE_IDLE;
            tx_done_next = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_state_reg <= LINE_IDLE;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h000;
      tx_cfg_reg <= '0;
      tx_done_reg <= 1'b0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_tick_reg <= tx_tick_next;
      tx_bit_reg <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      tx_cfg_reg <= tx_cfg_next;
      tx_done_reg <= tx_done_next;
    end
  end

  assign tx_busy = (tx_state_reg != LINE_IDLE);
  assign tx_done = tx_done_reg;
  assign tx_line = (tx_state_reg == LINE_START) ? 1'b0 :
                   (tx_state_reg == LINE_DATA) ? tx_shift_reg[0] : 1'b1;

  // ****************************************
  // Receiver
  // ****************************************
  line_state_type rx_state_reg, rx_state_next;
  logic [3:0] rx_tick_reg, rx_tick_next, rx_bit_reg, rx_bit_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  frame_cfg_type rx_cfg_reg, rx_cfg_next;
  rx_word_type rx_word_reg, rx_word_next;
  logic rx_done_reg, rx_done_next;
  logic [7:0] idle_cnt_reg, idle_cnt_next;
  logic idle_armed_reg, idle_armed_next, idle_reg, idle_next;
  logic [8:0] rx_data;
  logic byte_err, lin_err;

  // Received word right-aligned whatever its length
  always_comb
  begin
    rx_data = rx_cfg_reg.nine_bits ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    byte_err = ^rx_data ^ rx_cfg_reg.parity_odd;
    lin_err = (rx_data[6] != (rx_data[0] ^ rx_data[1] ^ rx_data[2] ^
               rx_data[4])) ||
              (rx_data[7] != ~(rx_data[1] ^ rx_data[3] ^ rx_data[4] ^
               rx_data[5]));
  end

  // Start bit checked at mid-bit to reject glitches
  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_tick_next = rx_tick_reg;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_cfg_next = rx_cfg_reg;
    rx_word_next = rx_word_reg;
    rx_done_next = 1'b0;
    idle_cnt_next = idle_cnt_reg;
    idle_armed_next = idle_armed_reg;
    idle_next = 1'b0;
    case (rx_state_reg)
      LINE_IDLE:
      begin
        if (!rx_line)
        begin
          rx_state_next = LINE_START;
          rx_tick_next = 4'h0;
          rx_cfg_next = cfg;
          idle_cnt_next = 8'h00;
          idle_armed_next = 1'b1;
        end
        else if (os_tick && idle_armed_reg)
        begin
          idle_cnt_next = idle_cnt_reg + 8'h01;
          if (idle_cnt_reg == (cfg.nine_bits ? IDLE_TICKS_9 : IDLE_TICKS_8))
          begin
            idle_next = 1'b1;
            idle_armed_next = 1'b0;
          end
        end
      end
      LINE_START:
      begin
        if (os_tick)
        begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_tick_reg == TICK_MID)
          begin
            rx_tick_next = 4'h0;
            rx_bit_next = 4'h0;
            rx_state_next = rx_line ? LINE_IDLE : LINE_DATA;
          end
        end
      end
      LINE_DATA:
      begin
        if (os_tick)
        begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_tick_reg == TICK_LAST)
          begin
            rx_shift_next = {rx_line, rx_shift_reg[8:1]};
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == (rx_cfg_reg.nine_bits ? 4'h8 : 4'h7))
              rx_state_next = LINE_STOP;
          end
        end
      end
      default:
      begin
        if (os_tick)
        begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_tick_reg == TICK_LAST)
          begin
            rx_state_next = LINE_IDLE;
            rx_done_next = 1'b1;
            rx_word_next.data = rx_data;
            rx_word_next.framing_error = !rx_line;
            rx_word_next.parity_error = rx_cfg_reg.parity_on &&
              (rx_cfg_reg.lin_parity ? lin_err : byte_err);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_state_reg <= LINE_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_cfg_reg <= '0;
      rx_word_reg <= '0;
      rx_done_reg <= 1'b0;
      idle_cnt_reg <= 8'h00;
      idle_armed_reg <= 1'b1;
      idle_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_tick_reg <= rx_tick_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_cfg_reg <= rx_cfg_next;
      rx_word_reg <= rx_word_next;
      rx_done_reg <= rx_done_next;
      idle_cnt_reg <= idle_cnt_next;
      idle_armed_reg <= idle_armed_next;
      idle_reg <= idle_next;
    end
  end

  assign rx_busy = (rx_state_reg != LINE_IDLE);
  assign rx_done = rx_done_reg;
  assign rx_word = rx_word_reg;
  assign idle_line = idle_reg;

endmodule
`default_nettype wire

// File: design/serial_frame_ctrl.sv
// Serial frame format and parity control with an AHB-Lite register file.
// Assumes one 10 MHz clock; the line pins are asynchronous to it.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_ctrl
  import serial_frame_pkg::*;
#(
  parameter int OS_DIV = OS_DIVIDE
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial line
  input wire logic rx_pin,
  output logic tx_pin,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Line synchroniser and prescaler
  // ****************************************
  logic rx_meta_reg, rx_sync_reg;
  logic [7:0] div_reg, div_next;
  logic os_tick_reg, os_tick_next;
  logic disabled_reg;

  // Prescaler halts while disabled to save power
  always_comb
  begin
    os_tick_next = 1'b0;
    div_next = 8'h00;
    if (!disabled_reg)
    begin
      if (div_reg == 8'(OS_DIV - 1))
        os_tick_next = 1'b1;
      else
        div_next = div_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      div_reg <= 8'h00;
      os_tick_reg <= 1'b0;
    end
    else
    begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
      div_reg <= div_next;
      os_tick_reg <= os_tick_next;
    end
  end

  // ****************************************
  // Frame engine
  // ****************************************
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] lin_reg, lin_next;
  logic tx_start_reg, tx_start_next;
  logic [7:0] tx_hold_reg, tx_hold_next;
  logic tx_busy, tx_done, tx_line, rx_busy, rx_done, idle_line;
  rx_word_type rx_word;
  frame_cfg_type cfg;

  // Format bits feed the engine, which latches them per frame
  always_comb
  begin
    cfg.nine_bits = ctrl_reg[CTRL_WORD9_BIT];
    cfg.parity_on = ctrl_reg[CTRL_PAR_ON_BIT];
    cfg.parity_odd = ctrl_reg[CTRL_ODD_BIT];
    cfg.lin_parity = lin_reg[LIN_PAR_BIT];
  end

  serial_frame_engine engine
  (
    .clock(clock),
    .rst(rst),
    .os_tick(os_tick_reg),
    .cfg(cfg),
    .tx_start(tx_start_reg),
    .tx_word({ctrl_reg[CTRL_TX9_BIT], tx_hold_reg}),
    .tx_busy(tx_busy),
    .tx_done(tx_done),
    .tx_line(tx_line),
    .rx_line(rx_sync_reg),
    .rx_busy(rx_busy),
    .rx_done(rx_done),
    .rx_word(rx_word),
    .idle_line(idle_line)
  );

  // ****************************************
  // Register file and bus slave
  // ****************************************
  logic pe_reg, pe_next, fe_reg, fe_next;
  logic rx_ready_reg, rx_ready_next, tx_empty_reg, tx_empty_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic [IRQ_WIDTH-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_WIDTH-1:0] irq_mask_reg, irq_mask_next;
  logic [IRQ_WIDTH-1:0] events;
  logic armed_reg, armed_next, disabled_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic irq_reg, irq_next, tx_pin_reg, tx_pin_next;
  logic rd_acc, accept, mark_wake;

  // Bus accesses first, hardware events last so a hardware event beats a bus write
  always_comb
  begin
    ctrl_next = ctrl_reg;
    lin_next = lin_reg;
    tx_hold_next = tx_hold_reg;
    pe_next = pe_reg;
    fe_next = fe_reg;
    rx_ready_next = rx_ready_reg;
    tx_empty_next = tx_empty_reg;
    rx_data_next = rx_data_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    armed_next = armed_reg;
    events = '0;
    accept = hsel && htrans[1] && hready;
    rd_acc = accept && !hwrite;
    wr_pend_next = accept && hwrite;
    wr_addr_next = accept ? haddr[7:0] : wr_addr_reg;
    hrdata_next = 32'h0000_0000;
    // Read data is captured in the address phase
    if (rd_acc)
    begin
      if (haddr[7:0] == FRAME_CTRL_OFS)
        hrdata_next[7:0] = ctrl_reg;
      else if (haddr[7:0] == STATUS_OFS)
      begin
        hrdata_next[STAT_PE_BIT] = pe_reg;
        hrdata_next[STAT_FE_BIT] = fe_reg;
        hrdata_next[STAT_RXRDY_BIT] = rx_ready_reg;
        hrdata_next[STAT_TXEMPTY_BIT] = tx_empty_reg;
        armed_next = 1'b1;
      end
      else if (haddr[7:0] == DATA_OFS)
      begin
        hrdata_next[7:0] = rx_data_reg;
        if (armed_reg)
        begin
          pe_next = 1'b0;
          fe_next = 1'b0;
          rx_ready_next = 1'b0;
          armed_next = 1'b0;
        end
      end
      else if (haddr[7:0] == LIN_CTRL_OFS)
        hrdata_next[3:0] = lin_reg;
      else if (haddr[7:0] == IRQ_STAT_OFS)
        hrdata_next[IRQ_WIDTH-1:0] = irq_stat_reg;
      else if (haddr[7:0] == IRQ_MASK_OFS)
        hrdata_next[IRQ_WIDTH-1:0] = irq_mask_reg;
    end
    // Writes land in the data phase
    if (wr_pend_reg)
    begin
      if (wr_addr_reg == FRAME_CTRL_OFS)
        ctrl_next = hwdata[7:0];
      else if (wr_addr_reg == DATA_OFS)
      begin
        tx_hold_next = hwdata[7:0];
        tx_empty_next = 1'b0;
        if (armed_reg)
        begin
          pe_next = 1'b0;
          armed_next = 1'b0;
        end
      end
      else if (wr_addr_reg == LIN_CTRL_OFS)
        lin_next = hwdata[3:0];
      else if (wr_addr_reg == IRQ_STAT_OFS)
        irq_stat_next = irq_stat_reg & ~hwdata[IRQ_WIDTH-1:0];
      else if (wr_addr_reg == IRQ_MASK_OFS)
        irq_mask_next = hwdata[IRQ_WIDTH-1:0];
    end
    // Hand a waiting byte to the transmitter unless disabling
    tx_start_next = 1'b0;
    if (!tx_empty_reg && !tx_busy && !tx_start_reg &&
        !ctrl_reg[CTRL_DIS_BIT])
    begin
      tx_start_next = 1'b1;
      tx_empty_next = 1'b1;
    end
    // Address-mark wake is not used in LIN mode
    mark_wake = ctrl_reg[CTRL_WAKE_BIT] && !lin_reg[LIN_MODE_BIT];
    if (lin_reg[LIN_MUTE_BIT])
    begin
      if (idle_line && !mark_wake)
        lin_next[LIN_MUTE_BIT] = 1'b0;
      else if (rx_done && mark_wake && (ctrl_reg[CTRL_WORD9_BIT] ?
               rx_word.data[8] : rx_word.data[7]))
        lin_next[LIN_MUTE_BIT] = 1'b0;
    end
    // A muted receiver drops words until woken
    if (rx_done && !(lin_reg[LIN_MUTE_BIT] && lin_next[LIN_MUTE_BIT]))
    begin
      rx_data_next = rx_word.data[7:0];
      rx_ready_next = 1'b1;
      events[IRQ_RX_BIT] = 1'b1;
      if (ctrl_reg[CTRL_WORD9_BIT])
        ctrl_next[CTRL_RX9_BIT] = rx_word.data[8];
      if (rx_word.parity_error)
      begin
        pe_next = 1'b1;
        events[IRQ_PE_BIT] = 1'b1;
      end
      if (rx_word.framing_error)
      begin
        fe_next = 1'b1;
        events[IRQ_FE_BIT] = 1'b1;
      end
    end
    events[IRQ_TX_BIT] = tx_done;
    irq_stat_next = irq_stat_next | events;
    // Stop only once no byte is on the wire in either direction
    disabled_next = ctrl_reg[CTRL_DIS_BIT] && (disabled_reg ||
      (!tx_busy && !rx_busy && !tx_start_reg));
    tx_pin_next = disabled_reg ? 1'b1 : tx_line;
    irq_next = (pe_reg && ctrl_reg[CTRL_PIE_BIT] &&
                ctrl_reg[CTRL_PAR_ON_BIT]) ||
               (|(irq_stat_reg & irq_mask_reg));
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
      lin_reg <= LIN_RESET;
      tx_hold_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      rx_data_reg <= 8'h00;
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      armed_reg <= 1'b0;
      disabled_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      tx_pin_reg <= 1'b1;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      lin_reg <= lin_next;
      tx_hold_reg <= tx_hold_next;
      tx_start_reg <= tx_start_next;
      pe_reg <= pe_next;
      fe_reg <= fe_next;
      rx_ready_reg <= rx_ready_next;
      tx_empty_reg <= tx_empty_next;
      rx_data_reg <= rx_data_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      armed_reg <= armed_next;
      disabled_reg <= disabled_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      irq_reg <= irq_next;
      tx_pin_reg <= tx_pin_next;
    end
  end

  // Zero wait states and always OKAY
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign tx_pin = tx_pin_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// File: tb/serial_frame_ctrl_sva.sv
// Port-level checker for the serial frame control block.
// Assumes the bind below and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_ctrl_sva
  import serial_frame_pkg::*;
#(
  parameter int OS_DIV = OS_DIVIDE
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Line and interrupt
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic irq
);
  // ****
  // Shadow of the interrupt enables
  // ****
  logic wr_phase;
  logic rd_phase;
  logic [7:0] wr_addr;
  logic pie_on;
  logic mask_on;
  // Writes land at the end of the data phase
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      wr_phase <= 1'b0;
      rd_phase <= 1'b0;
      wr_addr <= 8'h00;
      pie_on <= 1'b0;
      mask_on <= 1'b0;
    end
    else
    begin
      wr_phase <= hsel & htrans[1] & hwrite & hready;
      rd_phase <= hsel & htrans[1] & !hwrite & hready;
      wr_addr <= haddr[7:0];
      if (wr_phase && wr_addr == FRAME_CTRL_OFS)
        pie_on <= hwdata[CTRL_PIE_BIT] & hwdata[CTRL_PAR_ON_BIT];
      if (wr_phase && wr_addr == IRQ_MASK_OFS)
        mask_on <= |hwdata[3:0];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_ready_high: assert property (hreadyout)
    else $error("bus slave not ready");
  chk_resp_okay: assert property (!hresp)
    else $error("bus error response");
  chk_reset_idle: assert property ($fell(rst) |-> tx_pin && !irq)
    else $error("line or interrupt active after reset");
  chk_rdata_idle: assert property (!rd_phase |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data bits set");
  chk_start_width: assert property ($fell(tx_pin) |-> !tx_pin[*8])
    else $error("start bit too short");
  chk_bit_hold: assert property ($rose(tx_pin) |-> tx_pin[*8])
    else $error("high line bit too short");
  chk_irq_masked: assert property
    ((!pie_on && !mask_on)[*3] |-> !irq)
    else $error("interrupt with every source disabled");
endmodule
bind serial_frame_ctrl serial_frame_ctrl_sva #(.OS_DIV(OS_DIV)) chk (
  .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
`default_nettype wire

// File: tb/serial_node_model.sv
// Remote serial node: sends frames and samples frames it receives.
// Assumes idle-high line and a bit time of BT clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_node_model
#(
  parameter int BT = 32
)
(
  // Clock and format
  input wire logic clock,
  input wire logic nine,
  // Line
  input wire logic tx_pin,
  output logic rx_pin,
  // Received word, one-cycle strobe
  output logic got,
  output logic [8:0] word
);
  // ****
  // Sender and receiver
  // ****
  initial
  begin
    rx_pin = 1'b1;
    got = 1'b0;
    word = 9'h000;
  end
  // Start, data least significant first, stop
  task send(input logic [8:0] w);
    rx_pin <= 1'b0;
    repeat (BT) @(posedge clock);
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      rx_pin <= w[i];
      repeat (BT) @(posedge clock);
    end
    rx_pin <= 1'b1;
    repeat (BT) @(posedge clock);
  endtask
  // Sample mid-bit so small clock skew cannot move a bit
  initial
    forever
    begin
      @(negedge tx_pin);
      repeat (BT / 2) @(posedge clock);
      word = 9'h000;
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
        repeat (BT) @(posedge clock);
        word[i] = tx_pin;
      end
      repeat (BT) @(posedge clock);
      got <= 1'b1;
      @(posedge clock);
      got <= 1'b0;
    end
endmodule
`default_nettype wire

// File: tb/serial_frame_parity_control_tb.sv
// Self-checking bench for the serial frame control block.
// Assumes OS_DIV of 2, so one bit is 32 clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_parity_control_tb;
  import serial_frame_pkg::*;
  logic clock = 0, rst = 1, hsel = 0, hwrite = 0, nine = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, rx_pin, tx_pin, irq, got, rd_phase = 0;
  logic [8:0] word, d;
  logic [31:0] rq[$];
  logic [8:0] wq[$];
  int miscompares = 0, samples_checked = 0;
  serial_frame_ctrl #(.OS_DIV(2)) dut (.clock(clock), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  serial_node_model #(.BT(32)) node (.clock(clock), .nine(nine),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .got(got), .word(word));
  // ****
  // Clock, checks and bus cycles
  // ****
  initial forever #50 clock = ~clock;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Oldest note is matched to each read or received word
  always @(posedge clock)
  begin
    if (rd_phase)
      check(hrdata, rq.pop_front());
    rd_phase = hsel & htrans[1] & !hwrite & hreadyout;
    if (got)
      check({23'h0, word}, {23'h0, wq.size() ? wq.pop_front() : ~word});
  end
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? v : 32'h0;
    if (!w)
      rq.push_back(v);
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
  endtask
  // Bounded wait for the node to report every expected word
  task wait_word;
    for (int i = 0; i < 900 && wq.size() > 0; i++) @(posedge clock);
    if (wq.size() > 0)
      miscompares++;
    // Let the stop bit end so no format change cuts a frame
    repeat (40) @(posedge clock);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the roughly 4000 cycles needed
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test;
  end
  // ****
  // Test sequence
  // ****
  initial
  begin
    void'($urandom(22848));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(0, FRAME_CTRL_OFS, 32'h0);
    bus(0, STATUS_OFS, 32'h80);
    bus(1, 8'h1c, 32'hff);
    bus(0, 8'h1c, 32'h0);
    $display("registers done");
    d = {1'b0, 8'($urandom)};
    wq.push_back({1'b0, ^d[6:0], d[6:0]});
    bus(1, FRAME_CTRL_OFS, 32'h4);
    bus(1, DATA_OFS, {24'h0, d[7:0]});
    bus(1, FRAME_CTRL_OFS, 32'h6);
    wait_word();
    for (int i = 0; i < 4; i++)
    begin
      d = {1'b0, 8'($urandom)};
      nine <= i[1];
      bus(1, FRAME_CTRL_OFS, i[1] ? 32'h10 | i[0] << 6 : 32'h4 | i[0] << 1);
      wq.push_back(i[1] ? {i[0], d[7:0]} : {1'b0, ^d[6:0] ^ i[0], d[6:0]});
      bus(1, DATA_OFS, {24'h0, d[7:0]});
      wait_word();
    end
    $display("transmit formats done");
    nine <= 1'b0;
    bus(1, FRAME_CTRL_OFS, 32'h5);
    node.send({1'b0, ~^d[6:0], d[6:0]});
    repeat (4) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    bus(0, STATUS_OFS, 32'ha1);
    wq.push_back(9'h000);
    bus(1, DATA_OFS, 32'h0);
    wait_word();
    bus(0, STATUS_OFS, 32'ha0);
    check({31'h0, irq}, 32'h0);
    // Zero byte passes even parity but fails the LIN check bits
    bus(1, LIN_CTRL_OFS, 32'h2);
    node.send(9'h000);
    bus(0, STATUS_OFS, 32'ha1);
    bus(1, LIN_CTRL_OFS, 32'h0);
    $display("parity error done");
    bus(1, IRQ_STAT_OFS, 32'hf);
    nine <= 1'b1;
    bus(1, FRAME_CTRL_OFS, 32'h10);
    node.send({1'b1, d[7:0]});
    repeat (4) @(posedge clock);
    bus(0, FRAME_CTRL_OFS, 32'h90);
    bus(0, IRQ_STAT_OFS, 32'h4);
    bus(1, IRQ_MASK_OFS, 32'h4);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    bus(1, IRQ_STAT_OFS, 32'h4);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    $display("ninth bit and interrupt done");
    nine <= 1'b0;
    bus(1, FRAME_CTRL_OFS, 32'h20);
    bus(1, DATA_OFS, {24'h0, d[7:0]});
    repeat (500) @(posedge clock);
    check({31'h0, tx_pin}, 32'h1);
    wq.push_back({1'b0, d[7:0]});
    bus(1, FRAME_CTRL_OFS, 32'h0);
    wait_word();
    $display("disable done");
    stop_test;
  end
endmodule
`default_nettype wire
